// >>> design/prefetch_cfg.svh
`ifndef PREFETCH_CFG_SVH
`define PREFETCH_CFG_SVH

// stream slots and their identifiers
`define STREAMS     4
`define ID_W        2

// effective and physical address layout
`define ADDR_W      32
`define BLOCK_SHIFT 5
`define PAGE_SHIFT  12
`define VPN_W       20
`define PPN_W       20

// translation buffer geometry, direct mapped on the low page bits
`define TLB_DEPTH   8
`define TLB_IDX_W   3
`define TLB_TAG_W   17

// stream descriptor widths
`define COUNT_W     8
`define STRIDE_W    16

// vector load beats into one destination register
`define VLD_BEATS   4
`define BEAT_W      2
`define WORD_W      32

`endif

// >>> design/prefetch_pkg.sv
package prefetch_pkg;
`include "prefetch_cfg.svh"

	// stream instruction kinds
	typedef enum logic [1:0] {
		CMD_TOUCH       = 2'h0,
		CMD_TOUCH_STORE = 2'h1,
		CMD_STOP        = 2'h2,
		CMD_STOP_ALL    = 2'h3
	} cmd_op_t;

	// per-slot stream state
	typedef enum logic [2:0] {
		SLOT_IDLE   = 3'h1,
		SLOT_ACTIVE = 3'h2,
		SLOT_SUSP   = 3'h4
	} slot_state_t;

	// walker states
	typedef enum logic [5:0] {
		ENG_IDLE   = 6'h01,
		ENG_LOOKUP = 6'h02,
		ENG_CHECK  = 6'h04,
		ENG_WALK   = 6'h08,
		ENG_PROBE  = 6'h10,
		ENG_FETCH  = 6'h20
	} eng_state_t;

	typedef struct packed {
		logic                        valid;
		cmd_op_t                     op;
		logic [`ID_W-1:0]            id;
		logic [`ADDR_W-1:0]          ea;
		logic [`COUNT_W-1:0]         count;
		logic signed [`STRIDE_W-1:0] stride;
	} stream_cmd_t;

	typedef struct packed {
		slot_state_t                 state;
		logic [`ADDR_W-1:0]          ea;
		logic [`COUNT_W-1:0]         count;
		logic signed [`STRIDE_W-1:0] stride;
		logic                        priv;
		logic                        for_store;
	} slot_t;

	typedef struct packed {
		logic                  valid;
		logic [`TLB_TAG_W-1:0] tag;
		logic [`PPN_W-1:0]     ppn;
		logic                  readable;
	} tlb_entry_t;

	typedef struct packed {
		logic              valid;
		logic              fault;
		logic              read_ok;
		logic [`PPN_W-1:0] ppn;
	} walk_rsp_t;

	typedef struct packed {
		logic               valid;
		logic               last_use;
		logic               coherence_keep;
		logic [`ADDR_W-1:0] addr;
	} access_t;

	typedef struct packed {
		logic               valid;
		logic               mark_lru;
		logic               bypass_mid;
		logic [`ADDR_W-1:0] addr;
	} hint_t;

	typedef struct packed {
		logic               start;
		logic               beat_valid;
		logic [`WORD_W-1:0] data;
		logic               tlb_inval;
	} vld_in_t;

	typedef struct packed {
		logic               we;
		logic [`BEAT_W-1:0] sel;
		logic [`WORD_W-1:0] wdata;
		logic               partial;
		logic               done;
	} vld_out_t;

endpackage

// >>> design/rr_arbiter.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module rr_arbiter
	import prefetch_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// requests and grant
	input  wire logic [`STREAMS-1:0]  req,
	input  wire logic                 take,
	output logic                      any,
	output logic [`ID_W-1:0]          grant_id
);

	typedef struct packed {
		logic [`ID_W-1:0] ptr; // last slot granted
	} arb_state_t;

	arb_state_t       st;        // registered state
	arb_state_t       next_st;   // next state
	logic [`ID_W-1:0] cand;      // candidate slot in the search

	// search starts just past the last winner, so no slot starves
	always_comb begin
		next_st  = st;
		any      = 1'b0;
		grant_id = st.ptr;
		cand     = st.ptr;
		for (int k = 1; k <= `STREAMS; k++) begin
			cand = `ID_W'(int'(st.ptr) + k);
			if (!any && req[cand]) begin
				any      = 1'b1;
				grant_id = cand;
			end
		end
		// pointer moves only when the grant is used
		if (take && any) begin
			next_st.ptr = grant_id;
		end
	end

	// state register, last slot so slot 0 wins first after reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st.ptr <= {`ID_W{1'b1}};
		end else begin
			st <= next_st;
		end
	end

endmodule // rr_arbiter

// >>> design/tlb_store.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module tlb_store
	import prefetch_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// read port, data one cycle later
	input  wire logic                  rd_en,
	input  wire logic [`TLB_IDX_W-1:0] rd_idx,
	output tlb_entry_t                 rd_entry,
	// fill port
	input  wire logic                  wr_en,
	input  wire logic [`TLB_IDX_W-1:0] wr_idx,
	input  tlb_entry_t                 wr_entry
);

	typedef struct packed {
		tlb_entry_t [`TLB_DEPTH-1:0] mem; // entries
		tlb_entry_t                  rd;  // read data register
	} tlb_state_t;

	tlb_state_t st;      // registered state
	tlb_state_t next_st; // next state

	// read sees the old entry when a fill hits the same index
	always_comb begin
		next_st = st;
		if (rd_en) begin
			next_st.rd = st.mem[rd_idx];
		end
		if (wr_en) begin
			next_st.mem[wr_idx] = wr_entry;
		end
	end

	// reset empties the buffer so no stale mapping survives
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_entry = st.rd;

endmodule // tlb_store

// >>> design/vector_stream_prefetch_engine.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
// Function
// - stream lives from touch until done
// - complete after all fetchable blocks fetched
// - stop ends stream; new touch supplants
// - four independent stream slots at once
// - cache hits skip fetch, advance quickly
// - no completion indication toward software
// - all four tagged streams are implemented
// - round-robin arbitration for memory access
// - buffer miss triggers walk and fill
// - streams continue across page boundaries
// - own storage fault cancels only that stream
// - barriers neither cancel nor stall streams
// - ordinary misses harmless; ordinary fault cancels
// - normal access MRU, last-use access LRU
// - LRU victim may bypass middle levels
// - vector load may leave register partial
// - exceptions suspend; return resumes existing streams
// - suspended while data translation disabled
// - suspended while privilege differs from start
// - untranslatable or protected block terminates quietly
module vector_stream_prefetch_engine
	import prefetch_pkg::*;
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               reset,
	// stream instructions from the core
	input  stream_cmd_t             cmd,
	// machine state and exception events
	input  wire logic               data_translation_enable,
	input  wire logic               privilege_state_flag,
	input  wire logic               exception_taken,
	input  wire logic               exception_return,
	input  wire logic               ord_dsi,
	// page table search
	output logic                    walk_req,
	output logic [`VPN_W-1:0]       walk_vpn,
	input  walk_rsp_t               walk_rsp,
	// cache presence probe
	output logic                    probe_req,
	output logic [`ADDR_W-1:0]      probe_addr,
	input  wire logic               probe_rsp_valid,
	input  wire logic               probe_hit,
	// memory fetch of a missing block
	output logic                    fetch_req,
	output logic [`ADDR_W-1:0]      fetch_addr,
	output logic                    fetch_for_store,
	input  wire logic               fetch_ack,
	// replacement hints for ordinary and last-use accesses
	input  access_t                 access,
	output hint_t                   hint,
	// vector load destination writes
	input  vld_in_t                 vld_in,
	output vld_out_t                vld_out
);

	typedef struct packed {
		slot_t [`STREAMS-1:0]  slots;    // stream slots
		eng_state_t            eng;      // walker state
		logic [`ID_W-1:0]      cur_id;   // slot being served
		logic                  kill;     // served slot changed under us
		logic [`PPN_W-1:0]     ppn;      // translated page
		logic                  walk_req; // page table search pending
		logic [`VPN_W-1:0]     walk_vpn; // page being searched
		logic                  probe_req;
		logic [`ADDR_W-1:0]    probe_addr;
		logic                  fetch_req;
		logic [`ADDR_W-1:0]    fetch_addr;
		logic                  fetch_store;
		logic                  tlb_we;   // fill pulse
		logic [`TLB_IDX_W-1:0] tlb_widx;
		tlb_entry_t            tlb_went;
		logic                  in_exc;   // between exception and return
		hint_t                 hint;
		vld_out_t              vld;
		logic                  vld_busy; // vector load in progress
		logic [`BEAT_W-1:0]    vld_beat; // next word of the register
	} top_state_t;

	top_state_t          st;       // registered state
	top_state_t          next_st;  // next state
	slot_t               cur;      // slot being served
	logic [`STREAMS-1:0] run_req;  // slots asking for memory
	logic                arb_any;  // some slot is runnable
	logic [`ID_W-1:0]    arb_id;   // round-robin winner
	logic                arb_take; // winner accepted
	tlb_entry_t          rd_ent;   // looked-up entry
	logic                tlb_hit;  // entry matches the page
	logic                do_adv;   // block handled, step the stream
	logic                do_term;  // stream cannot go on

	assign cur = st.slots[st.cur_id];

	// only running slots compete; suspended slots keep their place
	always_comb begin
		for (int i = 0; i < `STREAMS; i++) begin
			run_req[i] = (st.slots[i].state == SLOT_ACTIVE);
		end
	end

	assign arb_take = (st.eng == ENG_IDLE) && arb_any;

	// fair grant among slots, one block per win
	rr_arbiter u_arb (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.req      (run_req),
		.take     (arb_take),
		.any      (arb_any),
		.grant_id (arb_id)
	);

	// translation buffer, indexed by the low page bits
	tlb_store u_tlb (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.rd_en    (st.eng == ENG_LOOKUP),
		.rd_idx   (cur.ea[`PAGE_SHIFT +: `TLB_IDX_W]),
		.rd_entry (rd_ent),
		.wr_en    (st.tlb_we),
		.wr_idx   (st.tlb_widx),
		.wr_entry (st.tlb_went)
	);

	// each block is translated on its own, so crossing a page is routine
	assign tlb_hit = rd_ent.valid &&
		(rd_ent.tag == cur.ea[`ADDR_W-1 -: `TLB_TAG_W]);

	// all next-state logic
	always_comb begin
		next_st = st;
		do_adv  = 1'b0;
		do_term = 1'b0;
		// one-cycle pulses drop by default
		next_st.tlb_we      = 1'b0;
		next_st.hint.valid  = 1'b0;
		next_st.vld.we      = 1'b0;
		next_st.vld.partial = 1'b0;
		next_st.vld.done    = 1'b0;

		// exception window, a new exception wins over a return
		if (exception_taken) begin
			next_st.in_exc = 1'b1;
		end else if (exception_return) begin
			next_st.in_exc = 1'b0;
		end

		// suspension is re-evaluated every cycle, exceptions never cancel
		for (int i = 0; i < `STREAMS; i++) begin
			if (st.slots[i].state != SLOT_IDLE) begin
				if (st.in_exc || !data_translation_enable ||
					(privilege_state_flag != st.slots[i].priv)) begin
					next_st.slots[i].state = SLOT_SUSP;
				end else begin
					next_st.slots[i].state = SLOT_ACTIVE;
				end
			end
		end

		// walker: one block at a time, translation then probe then fetch
		case (st.eng)
			ENG_IDLE: begin
				if (arb_any) begin
					next_st.cur_id = arb_id;
					next_st.kill   = 1'b0;
					next_st.eng    = ENG_LOOKUP;
				end
			end
			ENG_LOOKUP: begin
				// buffer read is in flight
				next_st.eng = ENG_CHECK;
			end
			ENG_CHECK: begin
				if (st.kill) begin
					next_st.eng = ENG_IDLE;
				end else if (tlb_hit && !rd_ent.readable) begin
					do_term     = 1'b1;
					next_st.eng = ENG_IDLE;
				end else if (tlb_hit) begin
					next_st.ppn        = rd_ent.ppn;
					next_st.probe_req  = 1'b1;
					next_st.probe_addr = {rd_ent.ppn,
						cur.ea[`PAGE_SHIFT-1:`BLOCK_SHIFT], {`BLOCK_SHIFT{1'b0}}};
					next_st.eng        = ENG_PROBE;
				end else begin
					// miss: search the page table rather than give up
					next_st.walk_req = 1'b1;
					next_st.walk_vpn = cur.ea[`ADDR_W-1:`PAGE_SHIFT];
					next_st.eng      = ENG_WALK;
				end
			end
			ENG_WALK: begin
				if (walk_rsp.valid) begin
					next_st.walk_req = 1'b0;
					if (walk_rsp.fault) begin
						// own fault: end this stream, raise nothing
						do_term     = 1'b1;
						next_st.eng = ENG_IDLE;
					end else begin
						// fill even when killed, the mapping is still good
						next_st.tlb_we   = 1'b1;
						next_st.tlb_widx = st.walk_vpn[`TLB_IDX_W-1:0];
						next_st.tlb_went = '{valid: 1'b1,
							tag: st.walk_vpn[`VPN_W-1 -: `TLB_TAG_W],
							ppn: walk_rsp.ppn, readable: walk_rsp.read_ok};
						if (!walk_rsp.read_ok) begin
							do_term     = 1'b1;
							next_st.eng = ENG_IDLE;
						end else if (st.kill) begin
							next_st.eng = ENG_IDLE;
						end else begin
							next_st.ppn        = walk_rsp.ppn;
							next_st.probe_req  = 1'b1;
							next_st.probe_addr = {walk_rsp.ppn,
								cur.ea[`PAGE_SHIFT-1:`BLOCK_SHIFT], {`BLOCK_SHIFT{1'b0}}};
							next_st.eng        = ENG_PROBE;
						end
					end
				end
			end
			ENG_PROBE: begin
				if (probe_rsp_valid) begin
					next_st.probe_req = 1'b0;
					if (probe_hit || st.kill) begin
						// present already or stream killed: no memory traffic for this block
						do_adv      = 1'b1;
						next_st.eng = ENG_IDLE;
					end else begin
						next_st.fetch_req   = 1'b1;
						next_st.fetch_addr  = st.probe_addr;
						next_st.fetch_store = cur.for_store;
						next_st.eng         = ENG_FETCH;
					end
				end
			end
			ENG_FETCH: begin
				// a fetch in flight finishes even if its stream is gone
				if (fetch_ack) begin
					next_st.fetch_req = 1'b0;
					do_adv            = 1'b1;
					next_st.eng       = ENG_IDLE;
				end
			end
			default: begin
				next_st.eng = ENG_IDLE;
			end
		endcase

		// step the stream; the last block ends it, nothing reports it
		if (do_adv && !st.kill) begin
			next_st.slots[st.cur_id].ea = cur.ea +
				{{(`ADDR_W-`STRIDE_W){cur.stride[`STRIDE_W-1]}}, cur.stride};
			next_st.slots[st.cur_id].count = cur.count - `COUNT_W'(1);
			if (cur.count <= `COUNT_W'(1)) begin
				next_st.slots[st.cur_id].state = SLOT_IDLE;
			end
		end
		if (do_term && !st.kill) begin
			next_st.slots[st.cur_id].state = SLOT_IDLE;
		end

		// instructions come after the walker so they override its update;
		// barriers have no path here, so they neither stop nor wait
		if (cmd.valid) begin
			case (cmd.op)
				CMD_TOUCH, CMD_TOUCH_STORE: begin
					// supplant at once, the old request is not queued
					next_st.slots[cmd.id] = '{
						state: (cmd.count == '0) ? SLOT_IDLE : SLOT_ACTIVE,
						ea: cmd.ea, count: cmd.count, stride: cmd.stride,
						priv: privilege_state_flag,
						for_store: (cmd.op == CMD_TOUCH_STORE)};
					if (next_st.eng != ENG_IDLE && cmd.id == next_st.cur_id) begin
						next_st.kill = 1'b1;
					end
				end
				CMD_STOP: begin
					next_st.slots[cmd.id].state = SLOT_IDLE;
					if (next_st.eng != ENG_IDLE && cmd.id == next_st.cur_id) begin
						next_st.kill = 1'b1;
					end
				end
				CMD_STOP_ALL: begin
					for (int i = 0; i < `STREAMS; i++) begin
						next_st.slots[i].state = SLOT_IDLE;
					end
					next_st.kill = (next_st.eng != ENG_IDLE);
				end
				default: begin
					next_st.kill = next_st.kill;
				end
			endcase
		end

		// a fault on an ordinary access cancels every stream; its misses do not
		if (ord_dsi) begin
			for (int i = 0; i < `STREAMS; i++) begin
				next_st.slots[i].state = SLOT_IDLE;
			end
			next_st.kill = (next_st.eng != ENG_IDLE);
		end

		// replacement hints: last-use marks LRU, everything else MRU
		if (access.valid) begin
			next_st.hint.valid      = 1'b1;
			next_st.hint.mark_lru   = access.last_use;
			next_st.hint.bypass_mid = access.last_use && !access.coherence_keep;
			next_st.hint.addr       = access.addr;
		end

		// vector load writes word by word; invalidation stops it midway
		if (vld_in.start) begin
			next_st.vld_busy = 1'b1;
			next_st.vld_beat = '0;
		end else if (st.vld_busy && vld_in.tlb_inval) begin
			// words already written stay, the register is left partial
			next_st.vld_busy    = 1'b0;
			next_st.vld.partial = 1'b1;
		end else if (st.vld_busy && vld_in.beat_valid) begin
			next_st.vld.we    = 1'b1;
			next_st.vld.sel   = st.vld_beat;
			next_st.vld.wdata = vld_in.data;
			next_st.vld_beat  = st.vld_beat + `BEAT_W'(1);
			if (st.vld_beat == `BEAT_W'(`VLD_BEATS-1)) begin
				next_st.vld_busy = 1'b0;
				next_st.vld.done = 1'b1;
			end
		end
	end

	// state register; slots start empty, walker idle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.eng <= ENG_IDLE;
			for (int i = 0; i < `STREAMS; i++) begin
				st.slots[i].state <= SLOT_IDLE;
			end
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign walk_req        = st.walk_req;
	assign walk_vpn        = st.walk_vpn;
	assign probe_req       = st.probe_req;
	assign probe_addr      = st.probe_addr;
	assign fetch_req       = st.fetch_req;
	assign fetch_addr      = st.fetch_addr;
	assign fetch_for_store = st.fetch_store;
	assign hint            = st.hint;
	assign vld_out         = st.vld;

endmodule // vector_stream_prefetch_engine

// >>> verification/prefetch_chk.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module prefetch_chk
	import prefetch_pkg::*;
(
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               reset,
	// translation, probe and fetch handshakes
	input wire logic               data_translation_enable,
	input wire logic               walk_req,
	input walk_rsp_t               walk_rsp,
	input wire logic               probe_req,
	input wire logic               probe_rsp_valid,
	input wire logic               probe_hit,
	input wire logic               fetch_req,
	input wire logic [`ADDR_W-1:0] fetch_addr,
	input wire logic               fetch_ack,
	// hints and vector writes
	input access_t                 access,
	input hint_t                   hint,
	input vld_out_t                vld_out
);
	// single domain: one clock, reset masks everything
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_walk_hold; walk_req && !walk_rsp.valid |=> walk_req; endproperty
	a_walk_hold: assert property (p_walk_hold) else $error("walk request dropped");
	property p_walk_end; walk_rsp.valid |=> !walk_req; endproperty
	a_walk_end: assert property (p_walk_end) else $error("walk request stuck");
	property p_probe_hold; probe_req && !probe_rsp_valid |=> probe_req; endproperty
	a_probe_hold: assert property (p_probe_hold) else $error("probe dropped");
	property p_miss_fetch; probe_rsp_valid && !probe_hit |=> fetch_req; endproperty
	a_miss_fetch: assert property (p_miss_fetch) else $error("miss not fetched");
	property p_hit_skip; probe_rsp_valid && probe_hit |=> !fetch_req; endproperty
	a_hit_skip: assert property (p_hit_skip) else $error("hit fetched again");
	// a fetch must keep its address until accepted
	property p_fetch_hold;
		fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch changed");
	property p_hint_lru;
		access.valid |=> hint.valid && hint.mark_lru == $past(access.last_use)
			&& hint.addr == $past(access.addr);
	endproperty
	a_hint_lru: assert property (p_hint_lru) else $error("bad lru hint");
	property p_hint_bypass;
		access.valid |=> hint.bypass_mid == $past(access.last_use && !access.coherence_keep);
	endproperty
	a_hint_bypass: assert property (p_hint_bypass) else $error("bad bypass");
	// eight cycles lets an in-flight block drain first
	property p_real_mode;
		!data_translation_enable [*8] |-> !$rose(walk_req) && !$rose(probe_req);
	endproperty
	a_real_mode: assert property (p_real_mode) else $error("ran untranslated");
	property p_vld_done; vld_out.done |-> vld_out.we && vld_out.sel == 2'h3; endproperty
	a_vld_done: assert property (p_vld_done) else $error("bad done beat");
	c_fetch: cover property (fetch_req && fetch_ack);
	c_hit: cover property (probe_rsp_valid && probe_hit);
	c_part: cover property (vld_out.partial);
endmodule // prefetch_chk

// >>> verification/core_side_model.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module core_side_model
	import prefetch_pkg::*;
#(
	parameter logic [`PPN_W-1:0] KEY = 20'h5a5a5
)
(
	// clock and reset
	input wire logic              sys_clk,
	input wire logic              reset,
	// behaviour knobs
	input wire logic              hit_mode,
	input wire logic              fault_mode,
	input wire logic              slow,
	// page walk
	input wire logic              walk_req,
	input wire logic [`VPN_W-1:0] walk_vpn,
	output walk_rsp_t             walk_rsp,
	// cache probe and fetch
	input wire logic              probe_req,
	output logic                  probe_rsp_valid,
	output logic                  probe_hit,
	input wire logic              fetch_req,
	output logic                  fetch_ack
);
	logic [2:0] req;         // fetch, probe, walk
	logic [2:0] ans;         // one-cycle answers
	logic [2:0] served;      // answered, waiting for release
	logic [1:0] dly [3];     // per channel wait
	logic [`PPN_W-1:0] last; // last translation given
	assign req = {fetch_req, probe_req, walk_req};
	// answer each held request once, then wait for release
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ans <= '0;
			served <= '0;
			last <= '0;
			for (int i = 0; i < 3; i++) dly[i] <= '0;
		end else begin
			if (ans[0]) last <= walk_rsp.ppn;
			for (int i = 0; i < 3; i++) begin
				ans[i] <= 1'b0;
				if (!req[i]) begin
					served[i] <= 1'b0;
					dly[i] <= slow ? 2'h3 : 2'h0;
				end else if (!served[i] && !ans[i]) begin
					if (dly[i] == 2'h0) begin
						ans[i] <= 1'b1;
						served[i] <= 1'b1;
					end else dly[i] <= dly[i] - 2'h1;
				end
			end
		end
	end
	// outside an answer the fields show junk
	assign walk_rsp.valid = ans[0];
	assign walk_rsp.fault = ans[0] ? fault_mode : 1'b1;
	assign walk_rsp.read_ok = ans[0];
	assign walk_rsp.ppn = ans[0] ? walk_vpn ^ KEY : ~last;
	assign probe_rsp_valid = ans[1];
	assign probe_hit = ans[1] ? hit_mode : ~hit_mode;
	assign fetch_ack = ans[2];
endmodule // core_side_model

// >>> verification/vector_stream_prefetch_engine_tb.sv
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module vector_stream_prefetch_engine_tb
	import prefetch_pkg::*;
;
	localparam logic [19:0] KEY = 20'h5a5a5; // partner translation
	logic sys_clk = 0, reset = 1, dte = 1, priv = 0, exc_t = 0, exc_r = 0, dsi = 0;
	logic hit_mode = 0, fault_mode = 0, slow = 0, pw = 0, pp = 0;
	stream_cmd_t cmd = '0;
	walk_rsp_t wr;
	logic walk_req, probe_req, prv, phit, fetch_req, ffs, fack;
	logic [19:0] walk_vpn;
	logic [31:0] paddr, faddr, ea, b, d;
	access_t acc = '0;
	hint_t hint;
	vld_in_t vin = '0;
	vld_out_t vout;
	int fail_count = 0, n_checks = 0, walks = 0, rises = 0, partials = 0, seed = 58779;
	logic [32:0] fq [$]; // expected fetches
	hint_t hq [$];       // expected hints
	logic [33:0] vq [$]; // expected vector writes
	always #50 sys_clk = ~sys_clk;
	vector_stream_prefetch_engine dut (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
		.data_translation_enable(dte), .privilege_state_flag(priv),
		.exception_taken(exc_t), .exception_return(exc_r), .ord_dsi(dsi),
		.walk_req(walk_req), .walk_vpn(walk_vpn), .walk_rsp(wr),
		.probe_req(probe_req), .probe_addr(paddr), .probe_rsp_valid(prv),
		.probe_hit(phit), .fetch_req(fetch_req), .fetch_addr(faddr),
		.fetch_for_store(ffs), .fetch_ack(fack), .access(acc), .hint(hint),
		.vld_in(vin), .vld_out(vout));
	core_side_model #(.KEY(KEY)) far (.sys_clk(sys_clk), .reset(reset),
		.hit_mode(hit_mode), .fault_mode(fault_mode), .slow(slow),
		.walk_req(walk_req), .walk_vpn(walk_vpn), .walk_rsp(wr),
		.probe_req(probe_req), .probe_rsp_valid(prv), .probe_hit(phit),
		.fetch_req(fetch_req), .fetch_ack(fack));
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic issue(cmd_op_t op, logic [1:0] id, logic [31:0] a, logic [7:0] n,
		logic [15:0] st);
		tick;
		cmd = '{1'b1, op, id, a, n, st};
	endtask
	// pulses fall one edge later
	task automatic idle;
		tick;
		cmd.valid = 0;
		exc_t = 0;
		exc_r = 0;
		dsi = 0;
	endtask
	function automatic logic [31:0] phys(logic [31:0] a);
		return {a[31:12] ^ KEY, a[11:5], 5'h00};
	endfunction
	task automatic drain;
		for (int i = 0; i < 800 && fq.size() != 0; i++) @(posedge sys_clk);
		repeat (4) tick;
	endtask
	// settle, then count walks and probes
	task automatic activity(logic exp);
		repeat (16) tick;
		rises = 0;
		repeat (24) tick;
		check(rises != 0, exp);
	endtask
	// watcher pops the oldest note
	always @(posedge sys_clk) if (!reset) begin
		if (walk_req && !pw) walks++;
		if (probe_req && !pp || walk_req && !pw) rises++;
		pw <= walk_req;
		pp <= probe_req;
		if (fetch_req && fack) begin
			if (fq.size() == 0) check(1, 0);
			else check({ffs, faddr}, fq.pop_front());
		end
		if (hint.valid) begin
			if (hq.size() == 0) check(1, 0);
			else check(hint, hq.pop_front());
		end
		if (vout.we) begin
			if (vq.size() == 0) check(1, 0);
			else check({vout.sel, vout.wdata}, vq.pop_front());
		end
		if (vout.partial) partials++;
	end
	// a hang ends as a failure
	always begin
		repeat (30000) @(posedge sys_clk);
		fail_count++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		reset = 0;
		// stream crossing a page, misses fetched
		ea = $random(seed) & 32'hffff_f000;
		for (int i = 0; i < 3; i++) fq.push_back({1'b0, phys(ea + i * 32'h800)});
		issue(CMD_TOUCH, 2'h0, ea, 8'h03, 16'h0800);
		idle;
		drain;
		check(walks, 2);
		$display("test page_cross done");
		// fresh reset, four streams, slow far side
		reset = 1;
		slow = 1;
		repeat (2) tick;
		reset = 0;
		b = $random(seed) & 32'hffff_8000;
		for (int k = 0; k < 8; k++) fq.push_back({k[0], phys(b + ((k % 4) << 12) + (k / 4) * 32)});
		for (int k = 0; k < 4; k++) issue(k[0] ? CMD_TOUCH_STORE : CMD_TOUCH, k[1:0],
			b + (k << 12), 8'h02, 16'h0020);
		idle;
		drain;
		slow = 0;
		$display("test round_robin done");
		// suspend, resume, cancel and supplant, all probes hit
		hit_mode = 1;
		for (int s = 0; s < 15; s++) begin
			ea = $random(seed) & 32'hffff_ffe0;
			case (s)
				0: issue(CMD_TOUCH, 2'h0, ea, 8'hc8, 16'h0020);
				1: begin tick; exc_t = 1; end
				2: begin tick; exc_r = 1; end
				3: begin tick; dte = 0; end
				4: begin tick; dte = 1; end
				5, 6: begin tick; priv = ~priv; end
				7: begin tick; dsi = 1; end
				8: issue(CMD_TOUCH, 2'h1, ea, 8'hc8, 16'h0020);
				9: issue(CMD_STOP, 2'h1, ea, 8'h00, 16'h0000);
				10: issue(CMD_TOUCH, 2'h2, ea, 8'hc8, 16'h0020);
				11: issue(CMD_TOUCH, 2'h2, ea, 8'h01, 16'h0020);
				12: issue(CMD_TOUCH, 2'h2, ea, 8'hc8, 16'h0020);
				13: issue(CMD_STOP_ALL, 2'h2, ea, 8'h00, 16'h0000);
				default: begin fault_mode = 1; issue(CMD_TOUCH, 2'h3, ea, 8'h02, 16'h0020); end
			endcase
			idle;
			activity(15'h1555 >> s);
		end
		fault_mode = 0;
		hit_mode = 0;
		$display("test stream_control done");
		// back-to-back replacement hints, every combination
		for (int k = 0; k < 4; k++) begin
			b = $random(seed);
			tick;
			acc = '{1'b1, k[1], k[0], b};
			hq.push_back('{1'b1, k[1], k[1] & ~k[0], b});
		end
		tick;
		acc.valid = 0;
		repeat (3) tick;
		$display("test hints done");
		// full vector load, then one cut short by invalidation
		for (int p = 0; p < 2; p++) begin
			tick;
			vin = '{1'b1, 1'b0, 32'h0, 1'b0};
			for (int j = 0; j < (p ? 5 : 4); j++) begin
				d = $random(seed);
				tick;
				vin = '{1'b0, !(p && j == 2), d, p && j == 2};
				if (j < (p ? 2 : 4)) vq.push_back({j[1:0], d});
			end
			tick;
			vin = '0;
		end
		repeat (4) tick;
		check(partials, 1);
		check(fq.size() + hq.size() + vq.size(), 0);
		$display("test vector_load done");
		end_sim;
	end
endmodule // vector_stream_prefetch_engine_tb
bind vector_stream_prefetch_engine prefetch_chk u_chk (.sys_clk(sys_clk), .reset(reset),
	.data_translation_enable(data_translation_enable), .walk_req(walk_req),
	.walk_rsp(walk_rsp), .probe_req(probe_req), .probe_rsp_valid(probe_rsp_valid),
	.probe_hit(probe_hit), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
	.fetch_ack(fetch_ack), .access(access), .hint(hint), .vld_out(vld_out));
